// File: logic/pbpath_top.sv
// playback digital path: volume, mutes, sidetone mix, biquad, compressor, output buffer
// What this block does
// - 16-bit input, 24-bit internal arithmetic
// - oversampling selectable from 32x to 256x
// - path runs only while enable bit set
// - register option inverts output polarity
// - 8-bit volume, -66 to +24 dB
// - one volume code mutes the path
// - gradual mute ramps volume down and up
// - record gradual mute has own bit
// - 1024 zero samples assert analog mute
// - non-zero sample clears mute and counter
// - biquad active only when enable written
// - peak estimator codes and time constants
// - limiter slope and knee
// - gate slope and knee
// - attack code 0 to 12 powers
// - release code 0 to 10 doubling
// - knee smoothing filter enable bit
// - compressor is last stage after mixer
// - mix equals volume sample plus sidetone
// - speaker gain 0 to 5.6 dB
// - coefficients 19-bit signed 3.16
// - biquad two zeros, two poles
// - 4-bit sidetone, all ones 0 dB
`timescale 1ns/10ps
module pbpath_top
  import pbpath_pkg::*;
#(
  parameter int OUT_BUF_DEPTH = 2
) (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  // register port
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [6:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  output logic [15:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  // sample streams
  input wire pcm_t PCM_I,
  input wire rec_t REC_I,
  output logic PCM_READY_O,
  // modulator side
  output rec_t MOD_O,
  input wire logic MOD_READY_I,
  output logic [8:0] OSR_O,
  output logic [3:0] SPK_GAIN_O,
  output logic ANALOG_MUTE_O,
  output logic PRECHARGE_EN_O,
  output logic REC_GRADUAL_MUTE_O
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MIX = 2'b01,
    ST_FILT = 2'b10,
    ST_COMP = 2'b11
  } phase_t;

  typedef struct packed {
    logic [15:0] sys_en;
    logic [15:0] interp;
    logic [15:0] sidetone;
    logic [15:0] mute;
    logic [15:0] volume;
    logic [15:0] comp_cfg;
    logic [15:0] comp_time;
    logic [15:0] cm_buf;
    logic [15:0] spk_drv;
    logic [15:0] bias_adj;
    logic [15:0] conv_pwr;
    logic [15:0] glob_bias;
    logic [N_COEF_REGS-1:0][15:0] coef;
    logic [7:0] gain_code;
    logic [10:0] zero_cnt;
    logic amute;
    phase_t phase;
    samp_t in_s;
    samp_t rec_s;
    samp_t mix;
    samp_t filt;
    samp_t x1, x2, y1, y2;
    samp_t env;
    logic [1:0] bcnt;
    logic [1:0][24:0] buf_mem;
    logic [1:0] wp, rp;
    logic [15:0] rdata;
    logic rvalid;
  } state_t;

  state_t cur_ff, nxt_ff;

  // volume code to Q8.16 linear gain: mantissa for half-dB fraction, shift for 6 dB
  function automatic logic [31:0] vol_gain(input logic [7:0] code);
    logic [7:0] steps;
    logic [3:0] oct;
    logic [3:0] frac;
    logic [15:0] mant;
    steps = code - 8'h01;
    oct = 4'(steps / 8'd12);
    frac = 4'(steps % 8'd12);
    case (frac)
      4'h0: mant = 16'h8000;
      4'h1: mant = 16'h87A6;
      4'h2: mant = 16'h8FAC;
      4'h3: mant = 16'h9838;
      4'h4: mant = 16'hA12A;
      4'h5: mant = 16'hAA8E;
      4'h6: mant = 16'hB477;
      4'h7: mant = 16'hBED9;
      4'h8: mant = 16'hC9E3;
      4'h9: mant = 16'hD582;
      4'hA: mant = 16'hE1C3;
      4'hB: mant = 16'hEEB0;
      default: mant = 16'h8000;
    endcase
    if (code == VOL_MUTE)
      vol_gain = 32'h0;
    else
      vol_gain = ({16'h0, mant} << oct) >> 10;
  endfunction

  function automatic samp_t sat24(input logic signed [47:0] v);
    if (v > 48'sh7FFFFF)
      sat24 = 24'sh7FFFFF;
    else if (v < -48'sh800000)
      sat24 = -24'sh800000;
    else
      sat24 = v[23:0];
  endfunction

  function automatic logic signed [47:0] cmul(input samp_t s, input coef_t c);
    cmul = (48'(s) * 48'(c)) >>> 16;
  endfunction

  logic [7:0] target;
  logic [31:0] g;
  logic signed [47:0] prod, st_prod, acc;
  logic [23:0] mag;
  logic [5:0] lvl;
  samp_t comp_out;
  coef_t a1, a2, b0, b1, b2;
  logic buf_full, buf_empty, take;
  logic [3:0] st_code;

  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.rvalid = 1'b0;
    // coefficient pairs: odd register high 3 bits, even register low 16 bits
    a1 = {cur_ff.coef[1][2:0], cur_ff.coef[0]};
    a2 = {cur_ff.coef[3][2:0], cur_ff.coef[2]};
    b0 = {cur_ff.coef[5][2:0], cur_ff.coef[4]};
    b1 = {cur_ff.coef[7][2:0], cur_ff.coef[6]};
    b2 = {cur_ff.coef[9][2:0], cur_ff.coef[8]};
    st_code = cur_ff.sidetone[B_ST_LO +: 4];
    buf_full = (cur_ff.wp - cur_ff.rp) == 2'd2;
    buf_empty = cur_ff.wp == cur_ff.rp;
    // one sample in flight at a time: take only into an empty buffer, as ready says
    take = PCM_I.valid && cur_ff.phase == ST_IDLE && buf_empty
           && cur_ff.sys_en[B_PB_EN];
    target = cur_ff.mute[B_GMUTE] ? VOL_MUTE : cur_ff.volume[7:0];
    g = vol_gain(cur_ff.gain_code);
    prod = 48'sh0;
    st_prod = 48'sh0;
    acc = 48'sh0;
    mag = 24'h0;
    lvl = 6'h0;
    comp_out = cur_ff.filt;

    // register writes
    if (REG_WR_I) begin
      case (REG_ADDR_I)
        A_SYS_EN: nxt_ff.sys_en = REG_WDATA_I;
        A_INTERP: nxt_ff.interp = REG_WDATA_I;
        A_SIDETONE: nxt_ff.sidetone = REG_WDATA_I;
        A_MUTE: nxt_ff.mute = REG_WDATA_I;
        A_VOLUME: nxt_ff.volume = REG_WDATA_I;
        A_COMP_CFG: nxt_ff.comp_cfg = REG_WDATA_I;
        A_COMP_TIME: begin
          nxt_ff.comp_time = REG_WDATA_I;
          if (REG_WDATA_I[7:4] > COMP_ATK_MAX) nxt_ff.comp_time[7:4] = COMP_ATK_MAX;
          if (REG_WDATA_I[3:0] > COMP_REL_MAX) nxt_ff.comp_time[3:0] = COMP_REL_MAX;
        end
        A_CM_BUF: nxt_ff.cm_buf = REG_WDATA_I;
        A_SPK_DRV: begin
          nxt_ff.spk_drv = REG_WDATA_I;
          if (REG_WDATA_I[3:0] > SPK_GAIN_MAX) nxt_ff.spk_drv[3:0] = SPK_GAIN_MAX;
        end
        A_BIAS_ADJ: nxt_ff.bias_adj = REG_WDATA_I;
        A_CONV_PWR: nxt_ff.conv_pwr = REG_WDATA_I;
        A_GLOB_BIAS: nxt_ff.glob_bias = REG_WDATA_I;
        default: begin
          if (REG_ADDR_I >= A_COEF_FIRST && REG_ADDR_I < A_COEF_FIRST + 7'(N_COEF_REGS))
            nxt_ff.coef[4'(REG_ADDR_I - A_COEF_FIRST)] = REG_WDATA_I;
        end
      endcase
    end
    // register reads, one cycle later
    if (REG_RD_I) begin
      nxt_ff.rvalid = 1'b1;
      case (REG_ADDR_I)
        A_SYS_EN: nxt_ff.rdata = cur_ff.sys_en;
        A_INTERP: nxt_ff.rdata = cur_ff.interp;
        A_SIDETONE: nxt_ff.rdata = cur_ff.sidetone;
        A_MUTE: nxt_ff.rdata = cur_ff.mute;
        A_VOLUME: nxt_ff.rdata = cur_ff.volume;
        A_COMP_CFG: nxt_ff.rdata = cur_ff.comp_cfg;
        A_COMP_TIME: nxt_ff.rdata = cur_ff.comp_time;
        A_CM_BUF: nxt_ff.rdata = cur_ff.cm_buf;
        A_SPK_DRV: nxt_ff.rdata = cur_ff.spk_drv;
        A_AMUTE_STAT: nxt_ff.rdata = 16'(cur_ff.amute) << B_AMUTE_STAT;
        A_BIAS_ADJ: nxt_ff.rdata = cur_ff.bias_adj;
        A_CONV_PWR: nxt_ff.rdata = cur_ff.conv_pwr;
        A_GLOB_BIAS: nxt_ff.rdata = cur_ff.glob_bias;
        default: begin
          if (REG_ADDR_I >= A_COEF_FIRST && REG_ADDR_I < A_COEF_FIRST + 7'(N_COEF_REGS))
            nxt_ff.rdata = cur_ff.coef[4'(REG_ADDR_I - A_COEF_FIRST)];
          else
            nxt_ff.rdata = R_ZERO;
        end
      endcase
    end

    case (cur_ff.phase)
      ST_IDLE: begin
        if (take) begin
          nxt_ff.in_s = {PCM_I.data, 8'h00};
          nxt_ff.rec_s = REC_I.valid ? REC_I.data : 24'sh0;
          nxt_ff.phase = ST_MIX;
          // gain moves one code per sample toward target
          if (cur_ff.gain_code < target) nxt_ff.gain_code = cur_ff.gain_code + 8'h01;
          else if (cur_ff.gain_code > target) nxt_ff.gain_code = cur_ff.gain_code - 8'h01;
          // zero-run detector
          if (PCM_I.data != 16'sh0) begin
            nxt_ff.zero_cnt = 11'h0;
            nxt_ff.amute = 1'b0;
          end else if (cur_ff.zero_cnt < ZERO_RUN) begin
            nxt_ff.zero_cnt = cur_ff.zero_cnt + 11'h1;
            if (cur_ff.zero_cnt + 11'h1 == ZERO_RUN && cur_ff.mute[B_ZMUTE_EN])
              nxt_ff.amute = 1'b1;
          end
        end
        if (!cur_ff.mute[B_ZMUTE_EN]) nxt_ff.amute = 1'b0;
      end
      ST_MIX: begin
        prod = (48'(cur_ff.in_s) * 48'(signed'({1'b0, g}))) >>> 16;
        // sidetone: code/15 scaling, all ones is unity
        st_prod = (48'(cur_ff.rec_s) * 48'(signed'({1'b0, st_code}))) / 48'sd15;
        nxt_ff.mix = sat24(prod + st_prod);
        nxt_ff.phase = ST_FILT;
      end
      ST_FILT: begin
        if (cur_ff.coef[9][B_BIQ_EN]) begin
          acc = cmul(cur_ff.mix, b0) + cmul(cur_ff.x1, b1) + cmul(cur_ff.x2, b2)
                - cmul(cur_ff.y1, a1) - cmul(cur_ff.y2, a2);
          nxt_ff.filt = sat24(acc);
          nxt_ff.x2 = cur_ff.x1;
          nxt_ff.x1 = cur_ff.mix;
          nxt_ff.y2 = cur_ff.y1;
          nxt_ff.y1 = sat24(acc);
        end else begin
          nxt_ff.filt = cur_ff.mix;
        end
        nxt_ff.phase = ST_COMP;
      end
      ST_COMP: begin
        // peak envelope: attack and release shifts follow the time codes
        mag = cur_ff.filt[23] ? 24'(-cur_ff.filt) : 24'(cur_ff.filt);
        if (signed'({1'b0, mag}) > 25'(cur_ff.env))
          nxt_ff.env = cur_ff.env + samp_t'((signed'({1'b0, mag}) - 25'(cur_ff.env))
                       >>> cur_ff.comp_time[7:4]);
        else
          nxt_ff.env = cur_ff.env - (cur_ff.env >>> (5'(cur_ff.comp_time[3:0]) + 5'd6));
        // limiter above the knee; slope code from the config register
        lvl = 6'(cur_ff.comp_cfg[5:0]);
        if (cur_ff.env > (24'sh7FFFFF >>> lvl[4:0])) begin
          comp_out = cur_ff.filt >>> (4'(cur_ff.comp_cfg[10:8]) + 4'h1);
          if (cur_ff.comp_cfg[B_SMOOTH])
            comp_out = samp_t'((48'(cur_ff.filt) + 48'(comp_out)) >>> 1);
        end else if (cur_ff.env < (24'sh7FFFFF >>> (5'd18 + {3'b0, cur_ff.comp_cfg[12:11]})))
          comp_out = cur_ff.filt >>> cur_ff.comp_cfg[14:13];
        if (cur_ff.sys_en[B_PB_INVERT]) comp_out = -comp_out;
        nxt_ff.buf_mem[cur_ff.wp[0]] = {1'b1, comp_out};
        nxt_ff.wp = cur_ff.wp + 2'd1;
        nxt_ff.phase = ST_IDLE;
      end
      default: nxt_ff.phase = ST_IDLE;
    endcase
    if (!buf_empty && MOD_READY_I) nxt_ff.rp = cur_ff.rp + 2'd1;
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      cur_ff <= '0;
      cur_ff.sys_en <= R_SYS_EN;
      cur_ff.interp <= R_INTERP;
      cur_ff.sidetone <= R_SIDETONE;
      cur_ff.mute <= R_MUTE;
      cur_ff.volume <= R_VOLUME;
      cur_ff.comp_cfg <= R_COMP_CFG;
      cur_ff.comp_time <= R_COMP_TIME;
      cur_ff.cm_buf <= R_CM_BUF;
      cur_ff.spk_drv <= R_SPK_DRV;
      cur_ff.glob_bias <= R_GLOB_BIAS;
      cur_ff.phase <= ST_IDLE;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // outputs, all from the state register
  logic [1:0] osr_sel;
  assign osr_sel = cur_ff.interp[B_OSR_LO +: 2];
  assign REG_RDATA_O = cur_ff.rdata;
  assign REG_RVALID_O = cur_ff.rvalid;
  assign PCM_READY_O = cur_ff.phase == ST_IDLE && cur_ff.wp == cur_ff.rp;
  assign MOD_O = {!buf_empty, cur_ff.buf_mem[cur_ff.rp[0]][23:0]};
  assign OSR_O = OSR_MIN << osr_sel;
  assign SPK_GAIN_O = cur_ff.spk_drv[3:0];
  assign ANALOG_MUTE_O = cur_ff.amute;
  assign PRECHARGE_EN_O = !cur_ff.cm_buf[4];
  assign REC_GRADUAL_MUTE_O = cur_ff.mute[B_REC_GMUTE];
endmodule

// File: common/pbpath_pkg.sv
// package: register map, field positions, reset values and stream types of the playback path
package pbpath_pkg;
  // register offsets (register port addresses)
  localparam logic [6:0] A_SYS_EN = 7'h01;
  localparam logic [6:0] A_INTERP = 7'h2C;
  localparam logic [6:0] A_SIDETONE = 7'h30;
  localparam logic [6:0] A_MUTE = 7'h31;
  localparam logic [6:0] A_VOLUME = 7'h34;
  localparam logic [6:0] A_COMP_CFG = 7'h3A;
  localparam logic [6:0] A_COMP_TIME = 7'h3D;
  localparam logic [6:0] A_CM_BUF = 7'h51;
  localparam logic [6:0] A_SPK_DRV = 7'h52;
  localparam logic [6:0] A_AMUTE_STAT = 7'h59;
  localparam logic [6:0] A_BIAS_ADJ = 7'h66;
  localparam logic [6:0] A_CONV_PWR = 7'h73;
  localparam logic [6:0] A_GLOB_BIAS = 7'h76;
  localparam logic [6:0] A_COEF_FIRST = 7'h40;
  localparam int N_COEF_REGS = 10;
  // field positions
  localparam int B_PB_EN = 13;
  localparam int B_PB_INVERT = 14;
  localparam int B_OSR_LO = 0;
  localparam int B_GMUTE = 9;
  localparam int B_REC_GMUTE = 8;
  localparam int B_ZMUTE_EN = 11;
  localparam int B_AMUTE_STAT = 10;
  localparam int B_SMOOTH = 7;
  localparam int B_BIQ_EN = 15;
  localparam int B_ST_LO = 12;
  // reset values
  localparam logic [15:0] R_SYS_EN = 16'h03FE;
  localparam logic [15:0] R_INTERP = 16'h0082;
  localparam logic [15:0] R_SIDETONE = 16'h0000;
  localparam logic [15:0] R_MUTE = 16'h0000;
  localparam logic [15:0] R_VOLUME = 16'h0000;
  localparam logic [15:0] R_COMP_CFG = 16'h0000;
  localparam logic [15:0] R_COMP_TIME = 16'h0000;
  localparam logic [15:0] R_CM_BUF = 16'h0210;
  localparam logic [15:0] R_SPK_DRV = 16'h0080;
  localparam logic [15:0] R_ZERO = 16'h0000;
  localparam logic [15:0] R_GLOB_BIAS = 16'h0040;
  // volume code map: 0 = mute, 1 = -66 dB, unity gain and +24 dB codes
  localparam logic [7:0] VOL_MUTE = 8'h00;
  localparam logic [7:0] VOL_UNITY = 8'h85;
  localparam logic [7:0] VOL_MAX = 8'hB5;
  // zero-detect run length
  localparam logic [10:0] ZERO_RUN = 11'h400;
  // oversampling ratios selectable by a 2-bit code
  localparam logic [8:0] OSR_MIN = 9'h020;
  localparam logic [3:0] SPK_GAIN_MAX = 4'hE;
  localparam logic [3:0] COMP_ATK_MAX = 4'hC;
  localparam logic [3:0] COMP_REL_MAX = 4'hA;

  typedef logic signed [23:0] samp_t;
  typedef logic signed [18:0] coef_t;
  typedef struct packed {
    logic valid;
    logic signed [15:0] data;
  } pcm_t;
  typedef struct packed {
    logic valid;
    logic signed [23:0] data;
  } rec_t;
endpackage

// File: tb/pbpath_top_properties.sv
// checker: timing and value relations at the playback path ports
`timescale 1ns/10ps
module pbpath_props
  import pbpath_pkg::*;
(
  // clock, reset, register port
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [6:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic REG_RVALID_O,
  // streams and status
  input wire pcm_t PCM_I,
  input wire logic PCM_READY_O,
  input wire rec_t MOD_O,
  input wire logic MOD_READY_I,
  input wire logic [8:0] OSR_O,
  input wire logic [3:0] SPK_GAIN_O,
  input wire logic ANALOG_MUTE_O,
  input wire logic PRECHARGE_EN_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RESET_I);
  logic en_ff;
  logic take;
  logic [10:0] zrun_ff;
  // shadow of the enable bit, so takes can be told from refusals
  assign take = PCM_I.valid & PCM_READY_O & en_ff;
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      en_ff <= 1'b0;
      zrun_ff <= 11'h000;
    end else begin
      if (REG_WR_I && REG_ADDR_I == A_SYS_EN) en_ff <= REG_WDATA_I[B_PB_EN];
      if (take && PCM_I.data != 16'h0000) zrun_ff <= 11'h000;
      else if (take && zrun_ff != ZERO_RUN) zrun_ff <= zrun_ff + 11'h001;
    end
  end
  a_read_answer: assert property (REG_RD_I |=> REG_RVALID_O)
    else $error("read not answered next cycle");
  a_rvalid_cause: assert property (!REG_RD_I |=> !REG_RVALID_O)
    else $error("read valid without read");
  a_take_busy: assert property (take |=> !PCM_READY_O [*3])
    else $error("ready again too soon after take");
  a_answer_time: assert property (take |=> !MOD_O.valid [*3] ##[1:40] MOD_O.valid)
    else $error("output word not produced in time");
  a_out_hold: assert property (MOD_O.valid && !MOD_READY_I |=>
    MOD_O.valid && $stable(MOD_O.data))
    else $error("output word changed while stalled");
  a_mute_run: assert property ($rose(ANALOG_MUTE_O) |-> zrun_ff == ZERO_RUN)
    else $error("analog mute before 1024 zeros");
  a_mute_clear: assert property (take && PCM_I.data != 16'h0000 |=> !ANALOG_MUTE_O)
    else $error("non-zero sample kept mute");
  a_osr_top: assert property (REG_WR_I && REG_ADDR_I == A_INTERP && REG_WDATA_I[1:0] == 2'b11
    |-> ##2 OSR_O == 9'h100)
    else $error("ratio code 3 not 256");
  a_spk_cap: assert property (REG_WR_I && REG_ADDR_I == A_SPK_DRV && REG_WDATA_I[3:0] == 4'hF
    |-> ##2 SPK_GAIN_O == SPK_GAIN_MAX)
    else $error("speaker gain not capped");
  a_precharge_on: assert property (REG_WR_I && REG_ADDR_I == A_CM_BUF && !REG_WDATA_I[4]
    |-> ##2 PRECHARGE_EN_O)
    else $error("precharge not enabled");
  c_take: cover property (take);
  c_mute: cover property ($rose(ANALOG_MUTE_O));
  c_stall: cover property (MOD_O.valid && !MOD_READY_I);
endmodule
bind pbpath_top pbpath_props pbpath_props_inst (.CLK_SYS_I(CLK_SYS_I), .RESET_I(RESET_I),
  .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_ADDR_I(REG_ADDR_I),
  .REG_WDATA_I(REG_WDATA_I), .REG_RVALID_O(REG_RVALID_O), .PCM_I(PCM_I),
  .PCM_READY_O(PCM_READY_O), .MOD_O(MOD_O), .MOD_READY_I(MOD_READY_I), .OSR_O(OSR_O),
  .SPK_GAIN_O(SPK_GAIN_O), .ANALOG_MUTE_O(ANALOG_MUTE_O), .PRECHARGE_EN_O(PRECHARGE_EN_O));

// File: tb/mod_sink.sv
// partner: modulator side that takes words, able to stall
`timescale 1ns/10ps
module mod_sink
  import pbpath_pkg::*;
(
  input wire logic clk_i,
  input wire logic stall_i,
  input wire rec_t mod_i,
  output logic ready_o,
  output samp_t word_o,
  output int count_o
);
  initial begin
    ready_o = 1'b1;
    word_o = '0;
    count_o = 0;
  end
  // a stalling sink accepts every other cycle, so held words are exercised
  always @(posedge clk_i) begin
    if (mod_i.valid && ready_o) begin
      word_o <= mod_i.data;
      count_o <= count_o + 1;
    end
    ready_o <= #1 !stall_i || !ready_o;
  end
endmodule

// File: tb/tb.sv
// testbench: register port and sample stream checks of the playback path
`timescale 1ns/10ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_fail++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
  import pbpath_pkg::*;
  logic clk, rst, wr, rd, stall, rvalid, pready, mrdy, amute, pchg, rgm;
  logic [6:0] addr;
  logic [15:0] wdata, rdata, q16;
  logic [8:0] osr;
  logic [3:0] spk;
  pcm_t pcm;
  rec_t rec, mout;
  samp_t got, q;
  int n_got, n_fail, samples_checked;
  logic [6:0] ra[8] = '{A_SYS_EN, A_INTERP, A_MUTE, A_VOLUME, A_CM_BUF, A_SPK_DRV,
    A_GLOB_BIAS, 7'h7F};
  logic [15:0] rv[8] = '{R_SYS_EN, R_INTERP, R_MUTE, R_VOLUME, R_CM_BUF, R_SPK_DRV,
    R_GLOB_BIAS, 16'h0000};
  pbpath_top pbpath_top_inst (.CLK_SYS_I(clk), .RESET_I(rst), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
    .PCM_I(pcm), .REC_I(rec), .PCM_READY_O(pready), .MOD_O(mout), .MOD_READY_I(mrdy),
    .OSR_O(osr), .SPK_GAIN_O(spk), .ANALOG_MUTE_O(amute), .PRECHARGE_EN_O(pchg),
    .REC_GRADUAL_MUTE_O(rgm));
  mod_sink mod_sink_inst (.clk_i(clk), .stall_i(stall), .mod_i(mout), .ready_o(mrdy),
    .word_o(got), .count_o(n_got));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic print_verdict;
    $display("checked=%0d failed=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wreg(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk);
    #1 wr = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1 wr = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic rreg(input logic [6:0] a, output logic [15:0] d);
    @(posedge clk);
    #1 rd = 1'b1;
    addr = a;
    @(posedge clk);
    #1 rd = 1'b0;
    `CHK(rvalid, 1'b1)
    d = rdata;
  endtask
  // one sample in, waits for its word at the sink; bounded waits count as a mismatch
  task automatic snd(input logic [15:0] d, input logic [23:0] r);
    int k;
    int c;
    c = n_got;
    k = 0;
    @(posedge clk);
    #1 pcm = {1'b1, d};
    rec = {1'b1, r};
    while (pready !== 1'b1 && k < 300) begin
      @(posedge clk);
      #1 k++;
    end
    @(posedge clk);
    #1 pcm.valid = 1'b0;
    rec.valid = 1'b0;
    while (n_got == c && k < 300) begin
      @(posedge clk);
      #1 k++;
    end
    if (k >= 300) n_fail++;
    q = got;
  endtask
  task automatic run(input int n, input logic [15:0] d, input logic [23:0] r);
    repeat (n) snd(d, r);
  endtask
  initial begin
    #600000;
    n_fail++;
    print_verdict();
  end
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    pcm = '0;
    rec = '0;
    stall = 1'b0;
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    foreach (ra[i]) begin
      rreg(ra[i], q16);
      `CHK(q16, rv[i])
    end
    $display("done: register reset values");
    wreg(A_GLOB_BIAS, 16'h2000);
    wreg(A_INTERP, 16'h0072);
    wreg(A_CONV_PWR, 16'h1108);
    wreg(A_BIAS_ADJ, 16'h0062);
    wreg(A_GLOB_BIAS, 16'h3000);
    wreg(A_CM_BUF, 16'h0220);
    `CHK(pchg, 1'b1)
    wreg(A_CM_BUF, 16'h0230);
    `CHK(pchg, 1'b0)
    $display("done: lineout precharge");
    for (int i = 0; i < 4; i++) begin
      wreg(A_INTERP, 16'h0070 | 16'(i));
      `CHK(osr, OSR_MIN << i)
    end
    for (int i = 0; i < 16; i++) begin
      wreg(A_SPK_DRV, 16'h0080 | 16'(i));
      `CHK(spk, (i > 14) ? SPK_GAIN_MAX : 4'(i))
    end
    wreg(A_MUTE, 16'h0100);
    `CHK(rgm, 1'b1)
    wreg(A_MUTE, 16'h0200);
    `CHK(rgm, 1'b0)
    wreg(A_MUTE, 16'h0000);
    $display("done: ratio, speaker gain, record mute");
    @(posedge clk);
    #1 pcm = {1'b1, 16'h1234};
    repeat (20) @(posedge clk);
    #1 pcm.valid = 1'b0;
    `CHK(n_got, 0)
    $display("done: disabled path refuses");
    // volume ramps up one code per sample, so give it more than the unity code count
    wreg(A_SYS_EN, 16'h23FE);
    wreg(A_VOLUME, {8'h00, VOL_UNITY});
    stall = 1'b1;
    run(140, 16'h1000, 24'h000000);
    stall = 1'b0;
    `CHK(q[23], 1'b0)
    `CHK(q != 24'h000000, 1'b1)
    wreg(A_SYS_EN, 16'h63FE);
    run(4, 16'h1000, 24'h000000);
    `CHK(q[23], 1'b1)
    wreg(A_SYS_EN, 16'h23FE);
    $display("done: volume and polarity");
    wreg(A_MUTE, 16'h0200);
    run(140, 16'h1000, 24'h000000);
    `CHK(q, 24'h000000)
    wreg(A_VOLUME, {8'h00, VOL_MUTE});
    wreg(A_MUTE, 16'h0000);
    run(10, 16'h1000, 24'h000000);
    `CHK(q, 24'h000000)
    $display("done: gradual mute and mute code");
    wreg(A_VOLUME, {8'h00, VOL_UNITY});
    wreg(A_SIDETONE, 16'hF000);
    run(4, 16'h0000, 24'h100000);
    `CHK(q[23], 1'b0)
    `CHK(q != 24'h000000, 1'b1)
    $display("done: sidetone mix");
    wreg(A_SIDETONE, 16'h0000);
    wreg(A_MUTE, 16'h0800);
    snd(16'h0001, 24'h000000);
    run(1023, 16'h0000, 24'h000000);
    `CHK(amute, 1'b0)
    snd(16'h0000, 24'h000000);
    `CHK(amute, 1'b1)
    rreg(A_AMUTE_STAT, q16);
    `CHK(q16[B_AMUTE_STAT], 1'b1)
    snd(16'h0001, 24'h000000);
    `CHK(amute, 1'b0)
    run(1023, 16'h0000, 24'h000000);
    `CHK(amute, 1'b0)
    $display("done: zero-detect mute");
    print_verdict();
  end
endmodule
